// *** hdl/isa_mode_pkg.sv ***
// constants, types and field layout for the isa mode and recode block
package isa_mode_pkg;
  // register port map
  localparam logic [3:0] ADDR_CFG3 = 4'h0;
  localparam logic [3:0] ADDR_DBG_CTRL = 4'h4;
  localparam int CFG3_RESET_ISA_BIT = 0;
  localparam int CFG3_EXC_ISA_BIT = 16;
  localparam int DBG_ISA_BIT = 0;
  localparam logic [31:0] READ_MASK = 32'h0001_0001;
  // mode encodings and position of the mode in addresses
  localparam logic MODE_LEGACY = 1'b0;
  localparam logic MODE_COMPACT = 1'b1;
  localparam int ISA_BIT = 0;
  // edges to wait in the settle state, after the one hold edge, before straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // compact size class field in the first halfword
  localparam int SIZE_LSB = 10;
  localparam logic [7:0] SHORT_CLASS = 8'h0e;
  // legacy major opcode tables, eight six-bit entries each
  localparam logic [47:0] OP_MAP16 = 48'h0000_0000_0000;
  localparam logic [47:0] OP_MAP32 = 48'h0000_0000_0000;
  localparam int OP_W = 6;
  localparam int HW = 16;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } init_e;
  typedef enum logic [2:0] {
    EXC_NORMAL = 3'b001,
    EXC_DEBUG = 3'b010,
    EXC_ERROR = 3'b100
  } exc_kind_e;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic isa;
  } redirect_s;
  typedef struct packed {
    logic valid;
    logic short_form;
    logic [31:0] pc;
    logic [31:0] instr;
  } decoded_s;
  typedef struct packed {
    logic valid;
    logic [31:0] value;
  } link_s;
  typedef struct packed {
    logic valid;
    exc_kind_e kind;
    logic [31:0] value;
  } save_s;
endpackage

// *** hdl/isa_mode_select_recode.sv ***
// isa mode keeper with compact to legacy fetch recoder
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module isa_mode_select_recode
  import isa_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // strap pins
  input wire logic reset_isa_pin,
  input wire logic exc_isa_pin,
  input wire logic debug_isa_pin,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // fetch stream
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_word,
  output logic fetch_ready,
  output decoded_s dec,
  // pipeline events
  input wire logic jal_valid,
  input wire logic jr_valid,
  input wire logic jr_link,
  input wire logic [31:0] jr_src,
  input wire logic [31:0] link_addr,
  input wire logic exc_valid,
  input wire exc_kind_e exc_kind,
  input wire logic [31:0] exc_victim_pc,
  input wire logic [31:0] exc_vector_pc,
  input wire logic eret_valid,
  input wire logic [31:0] eret_addr,
  // results
  output link_s link_wr,
  output save_s saved,
  output redirect_s redirect
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  init_e state;
  logic [1:0] settle_cnt;
  logic run;
  logic mode;
  logic reset_isa_strap_field;
  logic exception_isa_select;
  logic debug_isa_select;
  logic next_mode;
  logic flush;
  logic [31:0] next_target;
  logic [47:0] buf_q;
  logic [1:0] count;
  logic skip;
  logic [31:0] hw_pc;
  logic [15:0] hw0;
  logic [15:0] hw1;
  logic is16;
  logic [1:0] need;
  logic can_emit;
  logic [1:0] consume;
  logic [1:0] left;
  logic accept;
  logic [47:0] next_buf;
  logic [1:0] next_count;
  logic [31:0] recoded;

  assign run = (state == ST_RUN);

  ////////////////////////////////////////////////////////////
  // strap synchronisers, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {debug_isa_pin, exc_isa_pin, reset_isa_pin};
      sync_b <= sync_a;
    end
  end

  // init sequencer: straps are caught only once the sync has filled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_HOLD;
      settle_cnt <= 2'h0;
    end else begin
      case (state)
        ST_HOLD: begin
          state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + 2'h1;
          if (settle_cnt == STRAP_SETTLE - 2'h1) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // configuration fields: reset value from the pins, then exception and debug selects writable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_isa_strap_field <= MODE_LEGACY;
      exception_isa_select <= MODE_LEGACY;
      debug_isa_select <= MODE_LEGACY;
    end else if (state == ST_SETTLE && settle_cnt == STRAP_SETTLE - 2'h1) begin
      reset_isa_strap_field <= sync_b[0];
      exception_isa_select <= sync_b[1];
      debug_isa_select <= sync_b[2];
    end else if (reg_wr && reg_addr == ADDR_CFG3) begin
      exception_isa_select <= reg_wdata[CFG3_EXC_ISA_BIT];
    end else if (reg_wr && reg_addr == ADDR_DBG_CTRL) begin
      debug_isa_select <= reg_wdata[DBG_ISA_BIT];
    end
  end

  // read data one cycle after the strobe; the mode itself is never offered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd && reg_addr == ADDR_CFG3) begin
        reg_rdata[CFG3_RESET_ISA_BIT] <= reset_isa_strap_field;
        reg_rdata[CFG3_EXC_ISA_BIT] <= exception_isa_select;
      end else if (reg_rd && reg_addr == ADDR_DBG_CTRL) begin
        reg_rdata[DBG_ISA_BIT] <= debug_isa_select;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // next mode: exception entry beats return, return beats jump
  always_comb begin
    next_mode = mode;
    next_target = 32'h0;
    flush = 1'b0;
    if (run && exc_valid) begin
      flush = 1'b1;
      next_target = exc_vector_pc;
      case (exc_kind)
        EXC_DEBUG: next_mode = debug_isa_select;
        EXC_ERROR: next_mode = reset_isa_strap_field;
        default: next_mode = exception_isa_select;
      endcase
    end else if (run && eret_valid) begin
      flush = 1'b1;
      next_mode = eret_addr[ISA_BIT];
      next_target = {eret_addr[31:1], 1'b0};
    end else if (run && jr_valid) begin
      flush = 1'b1;
      next_mode = jr_src[ISA_BIT];
      next_target = {jr_src[31:1], 1'b0};
    end
  end

  // mode register, loaded at the same edge as the redirect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= MODE_LEGACY;
    end else if (state == ST_SETTLE && settle_cnt == STRAP_SETTLE - 2'h1) begin
      mode <= sync_b[0];
    end else begin
      mode <= next_mode;
    end
  end

  // redirect carries the new mode so the target fetches in it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redirect <= '0;
    end else begin
      redirect.valid <= flush;
      redirect.pc <= next_target;
      redirect.isa <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////
  // link writes hold the mode of the calling code in bit 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_wr <= '0;
    end else begin
      link_wr.valid <= run && (jal_valid || (jr_valid && jr_link));
      link_wr.value <= {link_addr[31:1], mode};
    end
  end

  // return address saved with the interrupted mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      saved <= '{valid: 1'b0, kind: EXC_NORMAL, value: 32'h0};
    end else begin
      saved.valid <= run && exc_valid;
      saved.kind <= exc_kind;
      saved.value <= {exc_victim_pc[31:1], mode};
    end
  end

  ////////////////////////////////////////////////////////////
  // halfword queue: hw0 is the oldest, low halfword of a word first
  assign hw0 = buf_q[15:0];
  assign hw1 = buf_q[31:16];
  assign is16 = (mode == MODE_COMPACT) && SHORT_CLASS[hw0[SIZE_LSB+2:SIZE_LSB]];
  assign need = is16 ? 2'h1 : 2'h2;
  assign can_emit = run && (count >= need);
  assign consume = can_emit ? need : 2'h0;
  assign left = count - consume;
  assign accept = fetch_valid && fetch_ready;

  // recode: short forms widen their fields, long forms swap the major op
  always_comb begin
    recoded = {hw1, hw0};
    if (is16) begin
      recoded = {OP_MAP16[hw0[SIZE_LSB+2:SIZE_LSB]*OP_W +: OP_W], 2'h0, hw0[9:7], 2'h0,
                 hw0[6:4], {12{hw0[3]}}, hw0[3:0]};
    end else if (mode == MODE_COMPACT) begin
      recoded = {OP_MAP32[hw0[SIZE_LSB+2:SIZE_LSB]*OP_W +: OP_W], hw0[9:0], hw1};
    end
  end

  // queue update; a misaligned target drops the leading halfword
  always_comb begin
    next_buf = buf_q >> (HW * consume);
    next_count = left;
    if (accept && skip) begin
      next_buf = next_buf | (48'(fetch_word[31:16]) << (HW * left));
      next_count = left + 2'h1;
    end else if (accept) begin
      next_buf = next_buf | (48'(fetch_word) << (HW * left));
      next_count = left + 2'h2;
    end
  end

  // queue registers, flushed whenever the flow is redirected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_q <= 48'h0;
      count <= 2'h0;
      skip <= 1'b0;
    end else if (flush) begin
      buf_q <= 48'h0;
      count <= 2'h0;
      skip <= next_target[1];
    end else begin
      buf_q <= next_buf;
      count <= next_count;
      if (accept) begin
        skip <= 1'b0;
      end
    end
  end

  // ready from a flop, so at most one halfword is waiting on accept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_ready <= 1'b0;
    end else if (flush) begin
      fetch_ready <= 1'b1;
    end else begin
      fetch_ready <= (state != ST_HOLD) && (next_count <= 2'h1);
    end
  end

  // address of the oldest queued halfword
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hw_pc <= 32'h0;
    end else if (flush) begin
      hw_pc <= next_target;
    end else begin
      hw_pc <= hw_pc + {29'h0, consume, 1'b0};
    end
  end

  // decoded output to the unchanged legacy pipeline
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec <= '0;
    end else begin
      dec.valid <= can_emit && !flush;
      dec.short_form <= is16;
      dec.pc <= hw_pc;
      dec.instr <= recoded;
    end
  end

  ////////////////////////////////////////////////////////////
  // checks
  property p_link_mode;
    @(posedge clk) disable iff (!nrst)
      (run && jal_valid) |=> (link_wr.valid && link_wr.value[0] == $past(mode));
  endproperty
  a_link_mode: assert property (p_link_mode) else $error("link bit 0 lost the mode");

  property p_jr_mode;
    @(posedge clk) disable iff (!nrst)
      (run && jr_valid && !exc_valid && !eret_valid) |=> (mode == $past(jr_src[0]) && redirect.valid);
  endproperty
  a_jr_mode: assert property (p_jr_mode) else $error("jump did not load mode");

  property p_exc_save;
    @(posedge clk) disable iff (!nrst)
      (run && exc_valid) |=> (saved.valid && saved.value[0] == $past(mode));
  endproperty
  a_exc_save: assert property (p_exc_save) else $error("saved mode wrong");

  property p_exc_normal;
    @(posedge clk) disable iff (!nrst)
      (run && exc_valid && exc_kind == EXC_NORMAL) |=> (mode == $past(exception_isa_select));
  endproperty
  a_exc_normal: assert property (p_exc_normal) else $error("handler mode wrong");

  property p_exc_debug;
    @(posedge clk) disable iff (!nrst)
      (run && exc_valid && exc_kind == EXC_DEBUG) |=> (mode == $past(debug_isa_select));
  endproperty
  a_exc_debug: assert property (p_exc_debug) else $error("debug mode wrong");

  property p_eret;
    @(posedge clk) disable iff (!nrst)
      (run && eret_valid && !exc_valid) |=> (mode == $past(eret_addr[0]));
  endproperty
  a_eret: assert property (p_eret) else $error("return mode wrong");

  property p_redirect;
    @(posedge clk) disable iff (!nrst)
      redirect.valid |-> (redirect.isa == mode && !dec.valid && count == 2'h0);
  endproperty
  a_redirect: assert property (p_redirect) else $error("target not in new mode");

  property p_reset_mode;
    @(posedge clk) disable iff (!nrst)
      (state == ST_SETTLE) ##1 (state == ST_RUN) |-> (mode == reset_isa_strap_field);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode wrong");

  property p_no_mode_read;
    @(posedge clk) disable iff (!nrst)
      reg_rd |=> ((reg_rdata & ~READ_MASK) == 32'h0);
  endproperty
  a_no_mode_read: assert property (p_no_mode_read) else $error("stray read bits");

  property p_queue;
    @(posedge clk) disable iff (!nrst)
      fetch_ready |-> (count <= 2'h1);
  endproperty
  a_queue: assert property (p_queue) else $error("queue overflow");

  property p_short_legacy;
    @(posedge clk) disable iff (!nrst)
      dec.valid && dec.short_form |-> (mode == MODE_COMPACT);
  endproperty
  a_short_legacy: assert property (p_short_legacy) else $error("short form in legacy");

endmodule

// *** verification/tb_isa_mode_select_recode.sv ***
// self-checking bench for the isa mode keeper and fetch recoder
`timescale 1ns/10ps
module tb_isa_mode_select_recode
  import isa_mode_pkg::*;
;
  logic clk;
  logic nrst;
  logic reset_isa_pin;
  logic exc_isa_pin;
  logic debug_isa_pin;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic fetch_valid;
  logic [31:0] fetch_word;
  logic fetch_ready;
  decoded_s dec;
  logic jal_valid;
  logic jr_valid;
  logic jr_link;
  logic [31:0] jr_src;
  logic [31:0] link_addr;
  logic exc_valid;
  exc_kind_e exc_kind;
  logic [31:0] exc_victim_pc;
  logic [31:0] exc_vector_pc;
  logic eret_valid;
  logic [31:0] eret_addr;
  link_s link_wr;
  save_s saved;
  redirect_s redirect;
  int n_errors;
  int cmp_count;

  isa_mode_select_recode dut (
    .clk(clk), .nrst(nrst), .reset_isa_pin(reset_isa_pin), .exc_isa_pin(exc_isa_pin),
    .debug_isa_pin(debug_isa_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_ready(fetch_ready), .dec(dec), .jal_valid(jal_valid), .jr_valid(jr_valid), .jr_link(jr_link),
    .jr_src(jr_src), .link_addr(link_addr), .exc_valid(exc_valid), .exc_kind(exc_kind),
    .exc_victim_pc(exc_victim_pc), .exc_vector_pc(exc_vector_pc), .eret_valid(eret_valid),
    .eret_addr(eret_addr), .link_wr(link_wr), .saved(saved), .redirect(redirect)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // 25 mhz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, report and finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // register port: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask

  // one pipeline event: 0 jal, 1 jr, 2 exception, 3 eret, 4 jr with link
  task automatic ev(input int which, input logic [31:0] a, input logic [31:0] b, input exc_kind_e k);
    @(posedge clk);
    case (which)
      0: begin
        jal_valid <= 1'b1;
        link_addr <= a;
      end
      1, 4: begin
        jr_valid <= 1'b1;
        jr_link <= (which == 4);
        jr_src <= a;
        link_addr <= b;
      end
      2: begin
        exc_valid <= 1'b1;
        exc_kind <= k;
        exc_victim_pc <= a;
        exc_vector_pc <= b;
      end
      default: begin
        eret_valid <= 1'b1;
        eret_addr <= a;
      end
    endcase
    @(posedge clk);
    jal_valid <= 1'b0;
    jr_valid <= 1'b0;
    jr_link <= 1'b0;
    exc_valid <= 1'b0;
    eret_valid <= 1'b0;
    #1;
  endtask

  task automatic redir(input logic [31:0] pc, input logic isa);
    chk("redirect valid", 32'h1, {31'h0, redirect.valid});
    chk("redirect pc", pc, redirect.pc);
    chk("redirect isa", {31'h0, isa}, {31'h0, redirect.isa});
  endtask

  task automatic lnk(input logic [31:0] v);
    chk("link valid", 32'h1, {31'h0, link_wr.valid});
    chk("link value", v, link_wr.value);
  endtask

  task automatic sav(input exc_kind_e k, input logic [31:0] v);
    chk("saved valid", 32'h1, {31'h0, saved.valid});
    chk("saved kind", {29'h0, k}, {29'h0, saved.kind});
    chk("saved value", v, saved.value);
  endtask

  // push one fetch word, then collect n decoded instructions two bytes apart;
  // the expected recoded word steps by one from ins for each further instruction
  task automatic fetch(input logic [31:0] w, input int n, input logic [31:0] pc0, input logic sf,
                       input logic [31:0] ins);
    int got;
    int k;
    logic done;
    got = 0;
    done = 1'b0;
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_word <= w;
    for (k = 0; k < 20 && !done; k++) begin
      @(posedge clk);
      if (fetch_ready === 1'b1) done = 1'b1;
    end
    fetch_valid <= 1'b0;
    if (!done) begin
      n_errors++;
      $display("MISMATCH fetch_ready expected 1 seen timeout");
      conclude();
    end else begin
      for (k = 0; k < 10; k++) begin
        #1;
        if (dec.valid === 1'b1) begin
          chk("dec pc", pc0 + 32'(2 * got), dec.pc);
          chk("dec short", {31'h0, sf}, {31'h0, dec.short_form});
          chk("dec instr", ins + 32'(got), dec.instr);
          got++;
        end
        @(posedge clk);
      end
      chk("dec count", 32'(n), 32'(got));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    reset_isa_pin = 1'b1;
    exc_isa_pin = 1'b0;
    debug_isa_pin = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fetch_valid = 1'b0;
    fetch_word = 32'h0;
    jal_valid = 1'b0;
    jr_valid = 1'b0;
    jr_link = 1'b0;
    jr_src = 32'h0;
    link_addr = 32'h0;
    exc_valid = 1'b0;
    exc_kind = EXC_NORMAL;
    exc_victim_pc = 32'h0;
    exc_vector_pc = 32'h0;
    eret_valid = 1'b0;
    eret_addr = 32'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // an event before the straps are captured must be ignored
    ev(0, 32'h0000_1000, 32'h0, EXC_NORMAL);
    chk("early link valid", 32'h0, {31'h0, link_wr.valid});
    repeat (6) @(posedge clk);
    rd("config after reset", ADDR_CFG3, 32'h0000_0001);
    rd("debug ctrl after reset", ADDR_DBG_CTRL, 32'h0000_0001);
    rd("unmapped read", 4'h8, 32'h0);
    ev(0, 32'h0000_1000, 32'h0, EXC_NORMAL);
    lnk(32'h0000_1001);
    // reset strap bit is read-only, exception select is writable
    wr(ADDR_CFG3, 32'hffff_fffe);
    rd("config after write", ADDR_CFG3, 32'h0001_0001);
    wr(ADDR_DBG_CTRL, 32'h0);
    rd("debug ctrl after write", ADDR_DBG_CTRL, 32'h0);
    ev(1, 32'h0000_0100, 32'h0, EXC_NORMAL);
    redir(32'h0000_0100, 1'b0);
    chk("jr link valid", 32'h0, {31'h0, link_wr.valid});
    ev(0, 32'h0000_2000, 32'h0, EXC_NORMAL);
    lnk(32'h0000_2000);
    fetch(32'h1234_5678, 1, 32'h0000_0100, 1'b0, 32'h1234_5678);
    ev(2, 32'h0000_0300, 32'h0000_0180, EXC_NORMAL);
    sav(EXC_NORMAL, 32'h0000_0300);
    redir(32'h0000_0180, 1'b1);
    ev(0, 32'h0000_2000, 32'h0, EXC_NORMAL);
    lnk(32'h0000_2001);
    ev(2, 32'h0000_0400, 32'h0000_0500, EXC_DEBUG);
    sav(EXC_DEBUG, 32'h0000_0401);
    redir(32'h0000_0500, 1'b0);
    ev(3, 32'h0000_0401, 32'h0, EXC_NORMAL);
    redir(32'h0000_0400, 1'b1);
    ev(2, 32'h0000_0600, 32'h0000_0700, EXC_ERROR);
    sav(EXC_ERROR, 32'h0000_0601);
    redir(32'h0000_0700, 1'b1);
    ev(3, 32'h0000_0600, 32'h0, EXC_NORMAL);
    redir(32'h0000_0600, 1'b0);
    // register jump with link saves the old mode and switches to compact
    ev(4, 32'h0000_0211, 32'h0000_3000, EXC_NORMAL);
    lnk(32'h0000_3000);
    redir(32'h0000_0210, 1'b1);
    fetch(32'h0402_0401, 2, 32'h0000_0210, 1'b1, 32'h1);
    // target on an odd halfword uses only the upper half of the first word
    ev(1, 32'h0000_0213, 32'h0, EXC_NORMAL);
    redir(32'h0000_0212, 1'b1);
    fetch(32'h0403_0000, 1, 32'h0000_0212, 1'b1, 32'h3);
    // a long compact form puts its first halfword on top
    fetch(32'habcd_0155, 1, 32'h0000_0214, 1'b0, 32'h0155_abcd);
    // a second reset with the opposite straps
    @(posedge clk);
    nrst <= 1'b0;
    reset_isa_pin <= 1'b0;
    exc_isa_pin <= 1'b1;
    debug_isa_pin <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    rd("config after second reset", ADDR_CFG3, 32'h0001_0000);
    rd("debug ctrl after second reset", ADDR_DBG_CTRL, 32'h0);
    ev(0, 32'h0000_4000, 32'h0, EXC_NORMAL);
    lnk(32'h0000_4000);
    ev(2, 32'h0000_0500, 32'h0000_0800, EXC_NORMAL);
    sav(EXC_NORMAL, 32'h0000_0500);
    redir(32'h0000_0800, 1'b1);
    conclude();
  end
endmodule
